// ---- hdl/adcts_adc_trigger_sequencer.sv ----
// trigger control, sequencing and arithmetic unit of the converter
//
// Overview of operation
// - one of eight inputs routed by channel field
// - external reference disables internal reference regulator
// - engine starts on start pulse; result goes to arithmetic
// - internal trigger restarts after each conversion with timing
// - trigger pin used only while external enable set
// - 11-bit accumulator with carry, copied at end
// - sample count field selects one to 256
// - modes average, maximum, minimum or raw
// - cycle ends after copy and done status low
// - enable rising edge begins a cycle
// - clearing enable mid-cycle lets cycle finish
// - done lowers status; interrupt low when unmasked
// - minimum, maximum, average always computed
// - selector bits choose which result is read
// - single sample gives identical four results
// - selector locked while a cycle runs
// - trigger edge polarity chosen by edge bit
// - external mode stays armed until trigger
// - after delay start only if trigger still active
// - wait time between conversions in multi-sample cycles
// - holdoff low ignores trigger after first sample
// - holdoff high needs trigger edge and level
`timescale 1ns/1ns
`default_nettype none
module adcts_adc_trigger_sequencer
    import adcts_pkg::*;
#(
    parameter int DELAY_STEP_CYCLES = DELAY_STEP_CYC,
    parameter int WAIT_UNIT_CYCLES  = WAIT_UNIT_CYC
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic [3:0]          regAddr,
    input  wire logic [7:0]          regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [7:0]          regRdata,
    input  wire logic                trigger_pin,
    output logic      [2:0]          channelSel,
    output logic                     refRegEnable,
    output logic                     engineStart,
    input  wire logic                engineDone,
    input  wire logic [RESULT_W-1:0] engineResult,
    output logic                     intN
);
    typedef struct packed {
        adcts_state_type     state;
        logic                trigMeta;
        logic                trigSync;
        logic                trigPrev;
        logic                enPrev;
        logic [7:0]          setup;
        logic [7:0]          dly;
        logic [3:0]          waitCode;
        logic [1:0]          mode;
        logic [1:0]          sel;
        logic                mask;
        logic                status;
        logic                intPend;
        logic [7:0]          snapSetup;
        logic [7:0]          snapDly;
        logic [3:0]          snapWait;
        logic [1:0]          snapMode;
        logic [CNT_W-1:0]    cnt;
        logic [8:0]          left;
        logic                edgeSeen;
        logic                first;
        logic [SUM_W-1:0]    sum;
        logic [RESULT_W-1:0] minV;
        logic [RESULT_W-1:0] maxV;
        logic [RESULT_W-1:0] lastV;
        logic [RESULT_W-1:0] resAvg;
        logic [RESULT_W-1:0] resMin;
        logic [RESULT_W-1:0] resMax;
        logic [RESULT_W-1:0] resLast;
        logic [ACC_W-1:0]    acc;
        logic [7:0]          rdata;
    } adcts_regs_type;

    adcts_regs_type r_reg;
    adcts_regs_type r_next;

    logic                busy;
    logic                extMode;
    logic                edgeHit;
    logic                trigActive;
    logic [RESULT_W-1:0] selVal;
    logic [RESULT_W-1:0] avgNow;
    logic [SUM_W-1:0]    sumNow;
    logic [RESULT_W-1:0] minNow;
    logic [RESULT_W-1:0] maxNow;
    logic [CNT_W-1:0]    waitCyc;
    logic [CNT_W-1:0]    delayCyc;

    assign busy       = (r_reg.state != ST_IDLE);
    assign extMode    = r_reg.snapDly[DLY_EXT_BIT];
    // polarity bit high selects the rising edge, active level high
    assign trigActive = r_reg.snapDly[DLY_EDGE_BIT] ? r_reg.trigSync
                                                    : ~r_reg.trigSync;
    assign edgeHit    = (r_reg.trigSync != r_reg.trigPrev) && trigActive;
    assign waitCyc    = CNT_W'(adcts_wait_mult(r_reg.snapWait) * WAIT_UNIT_CYCLES);
    assign delayCyc   = CNT_W'(r_reg.snapDly[3:0] * DELAY_STEP_CYCLES);
    assign sumNow     = r_reg.sum + SUM_W'(engineResult);
    assign minNow     = (r_reg.first || engineResult < r_reg.minV) ?
                        engineResult : r_reg.minV;
    assign maxNow     = (r_reg.first || engineResult > r_reg.maxV) ?
                        engineResult : r_reg.maxV;
    assign avgNow     = RESULT_W'(r_reg.sum >>
                        adcts_cnt_shift(r_reg.snapSetup[SET_CNT_LSB +: 3]));

    always_comb begin
        case (adcts_sel_type'(r_reg.sel))
            SEL_AVERAGE: selVal = r_reg.resAvg;
            SEL_MINIMUM: selVal = r_reg.resMin;
            SEL_MAXIMUM: selVal = r_reg.resMax;
            default:     selVal = r_reg.resLast;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        r_next.trigMeta = trigger_pin;
        r_next.trigSync = r_reg.trigMeta;
        r_next.trigPrev = r_reg.trigSync;
        r_next.enPrev   = r_reg.setup[SET_EN_BIT];
        // register writes
        if (regWr) begin
            case (regAddr)
                REG_SETUP:   r_next.setup    = regWdata;
                REG_DELAY:   r_next.dly      = regWdata;
                REG_WAIT:    r_next.waitCode = regWdata[3:0];
                REG_MODE:    r_next.mode     = regWdata[1:0];
                REG_MASK:    r_next.mask     = regWdata[0];
                REG_READ_HI: begin
                    if (!busy) begin
                        r_next.sel = regWdata[RD_SEL_LSB +: 2];
                    end
                end
                default: ;
            endcase
        end
        // register reads, data one cycle later
        r_next.rdata = 8'h00;
        if (regRd) begin
            case (regAddr)
                REG_SETUP:   r_next.rdata = r_reg.setup;
                REG_DELAY:   r_next.rdata = r_reg.dly;
                REG_WAIT:    r_next.rdata = {4'h0, r_reg.waitCode};
                REG_MODE:    r_next.rdata = {6'h00, r_reg.mode};
                REG_MASK:    r_next.rdata = {7'h00, r_reg.mask};
                REG_READ_HI: r_next.rdata = {r_reg.status, r_reg.sel,
                                             3'h0, selVal[9:8]};
                REG_READ_LO: r_next.rdata = selVal[7:0];
                REG_ACC_HI:  r_next.rdata = {5'h00, r_reg.acc[10:8]};
                REG_ACC_LO:  r_next.rdata = r_reg.acc[7:0];
                default:     r_next.rdata = 8'h00;
            endcase
            if (regAddr == REG_READ_HI) begin
                r_next.intPend = 1'b0;
            end
        end
        if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - CNT_W'(1);
        end
        case (r_reg.state)
            ST_IDLE: begin
                // enable low then high; a held enable starts nothing
                if (r_reg.setup[SET_EN_BIT] && !r_reg.enPrev) begin
                    r_next.snapSetup = r_reg.setup;
                    r_next.snapDly   = r_reg.dly;
                    r_next.snapWait  = r_reg.waitCode;
                    r_next.snapMode  = r_reg.mode;
                    r_next.status    = 1'b1;
                    r_next.first     = 1'b1;
                    r_next.sum       = '0;
                    r_next.left      = 9'(1) << adcts_cnt_shift(
                                       r_reg.setup[SET_CNT_LSB +: 3]);
                    r_next.state     = r_reg.dly[DLY_EXT_BIT] ?
                                       ST_ARMED : ST_START;
                end
            end
            ST_ARMED: begin
                if (edgeHit) begin
                    r_next.cnt   = delayCyc;
                    r_next.state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (r_reg.cnt == '0) begin
                    r_next.state = trigActive ? ST_START : ST_ARMED;
                end
            end
            ST_START: begin
                r_next.state = ST_CONV;
            end
            ST_CONV: begin
                if (engineDone) begin
                    r_next.first = 1'b0;
                    r_next.sum   = sumNow;
                    r_next.minV  = minNow;
                    r_next.maxV  = maxNow;
                    r_next.lastV = engineResult;
                    r_next.left  = r_reg.left - 9'(1);
                    r_next.edgeSeen = 1'b0;
                    r_next.cnt   = waitCyc;
                    r_next.state = (r_reg.left == 9'(1)) ? ST_FINISH
                                                         : ST_WAIT;
                end
            end
            ST_WAIT: begin
                // edges only count with holdoff; otherwise ignored
                if (edgeHit && r_reg.snapDly[DLY_HOLD_BIT]) begin
                    r_next.edgeSeen = 1'b1;
                end
                if (r_reg.cnt == '0) begin
                    if (!extMode || !r_reg.snapDly[DLY_HOLD_BIT]) begin
                        r_next.state = ST_START;
                    end else if (r_reg.edgeSeen && trigActive) begin
                        r_next.state = ST_START;
                    end else begin
                        r_next.state = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if ((edgeHit || r_reg.edgeSeen) && trigActive) begin
                    r_next.state = ST_START;
                end else if (!trigActive) begin
                    r_next.edgeSeen = 1'b0;
                end
            end
            ST_FINISH: begin
                r_next.resAvg  = avgNow;
                r_next.resMin  = r_reg.minV;
                r_next.resMax  = r_reg.maxV;
                r_next.resLast = r_reg.lastV;
                case (adcts_alu_type'(r_reg.snapMode))
                    ALU_AVERAGE: r_next.acc = {1'b0, avgNow};
                    ALU_MAXIMUM: r_next.acc = {1'b0, r_reg.maxV};
                    ALU_MINIMUM: r_next.acc = {1'b0, r_reg.minV};
                    default:     r_next.acc = {1'b0, r_reg.lastV};
                endcase
                r_next.status  = 1'b0;
                r_next.intPend = 1'b1;                               // set wins
                r_next.state   = ST_IDLE;
            end
            default: r_next.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_reg          <= '0;
            r_reg.state    <= ST_IDLE;
            r_reg.setup    <= SETUP_RST;
            r_reg.dly      <= DELAY_RST;
            r_reg.waitCode <= WAIT_RST;
            r_reg.mode     <= MODE_RST;
            r_reg.mask     <= MASK_RST;
            r_reg.status   <= STATUS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign regRdata     = r_reg.rdata;
    assign channelSel   = busy ? r_reg.snapSetup[SET_CH_LSB +: 3]
                               : r_reg.setup[SET_CH_LSB +: 3];
    assign refRegEnable = ~r_reg.setup[SET_REF_BIT];
    assign engineStart  = (r_reg.state == ST_START);
    assign intN         = ~(r_reg.intPend & ~r_reg.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_mux_follows_setup: assert property (
        !busy |-> channelSel == r_reg.setup[SET_CH_LSB +: 3])
        else $error("channel select differs from setup field");
    a_ref_regulator: assert property (
        $rose(r_reg.setup[SET_REF_BIT]) |-> !refRegEnable)
        else $error("regulator on with external reference");
    a_start_single: assert property (
        engineStart |=> !engineStart ##0 r_reg.state == ST_CONV)
        else $error("start pulse not one cycle");
    a_result_taken: assert property (
        (r_reg.state == ST_CONV && engineDone)
        |=> r_reg.lastV == $past(engineResult))
        else $error("engine result not taken");
    a_enable_rise: assert property (
        (r_reg.state == ST_IDLE && $rose(r_reg.setup[SET_EN_BIT])
         && !r_reg.dly[DLY_EXT_BIT]) |=> engineStart)
        else $error("enable rise did not start a cycle");
    a_count_load: assert property (
        $rose(busy) |-> r_reg.left ==
        ((r_reg.snapSetup[SET_CNT_LSB +: 3] == 3'h0) ? 9'h001
         : 9'h002 << r_reg.snapSetup[SET_CNT_LSB +: 3]))
        else $error("sample count not loaded");
    a_wait_entry: assert property (
        (r_reg.state == ST_CONV && engineDone && r_reg.left != 9'h001)
        |=> r_reg.state == ST_WAIT && r_reg.cnt != '0)
        else $error("no wait between samples");
    a_wait_quiet: assert property (
        (r_reg.state == ST_WAIT && r_reg.cnt != '0) |=> !engineStart)
        else $error("start before wait ended");
    a_auto_restart: assert property (
        (r_reg.state == ST_WAIT && r_reg.cnt == '0
         && !r_reg.snapDly[DLY_HOLD_BIT]) |=> engineStart)
        else $error("no start after wait");
    a_last_finish: assert property (
        (r_reg.state == ST_CONV && engineDone && r_reg.left == 9'h001)
        |=> r_reg.state == ST_FINISH
        ##1 (r_reg.state == ST_IDLE && !r_reg.status))
        else $error("cycle did not end after last sample");
    a_cycle_completes: assert property (
        (busy && r_reg.state != ST_FINISH) |=> busy)
        else $error("cycle left before finishing");
    a_done_irq: assert property (
        ($fell(r_reg.status) && !r_reg.mask) |-> !intN)
        else $error("done without interrupt");
    a_int_masked: assert property (
        r_reg.mask |-> intN)
        else $error("masked interrupt on the pin");
    a_ordered_results: assert property (
        $fell(r_reg.status) |-> r_reg.resMin <= r_reg.resAvg
        && r_reg.resAvg <= r_reg.resMax && r_reg.resMin <= r_reg.resLast
        && r_reg.resLast <= r_reg.resMax)
        else $error("results outside minimum and maximum");
    a_acc_average: assert property (
        ($fell(r_reg.status) && r_reg.snapMode == 2'h0)
        |-> r_reg.acc == {1'b0, r_reg.resAvg})
        else $error("accumulator differs from average");
    a_acc_raw: assert property (
        ($fell(r_reg.status) && r_reg.snapMode == 2'h3)
        |-> r_reg.acc == {1'b0, r_reg.resLast})
        else $error("accumulator differs from raw sample");
    a_single_equal: assert property (
        ($fell(r_reg.status) && r_reg.snapSetup[SET_CNT_LSB +: 3] == 3'h0)
        |-> r_reg.resMin == r_reg.resMax && r_reg.resMin == r_reg.resLast
            && r_reg.resAvg == r_reg.resLast)
        else $error("single sample results differ");
    a_sel_locked: assert property (
        busy && $past(busy) |-> $stable(r_reg.sel))
        else $error("selector changed during cycle");
    a_sync_chain: assert property (
        r_reg.trigSync == $past(r_reg.trigMeta))
        else $error("trigger skipped a synchroniser stage");
    a_ext_states: assert property (
        r_reg.state inside {ST_ARMED, ST_DELAY, ST_HOLD} |-> extMode)
        else $error("trigger states without external mode");
    a_armed_pending: assert property (
        r_reg.state == ST_ARMED |-> r_reg.status && !engineStart)
        else $error("armed cycle reports done");
    a_edge_polarity: assert property (
        (r_reg.state == ST_ARMED && (r_reg.trigSync == r_reg.trigPrev
         || r_reg.trigSync != r_reg.snapDly[DLY_EDGE_BIT]))
        |=> r_reg.state == ST_ARMED)
        else $error("trigger taken on the wrong edge");
    a_delay_level: assert property (
        (r_reg.state == ST_DELAY && r_reg.cnt == '0 && !trigActive)
        |=> r_reg.state == ST_ARMED)
        else $error("start after delay with inactive trigger");
    a_hold_level: assert property (
        (r_reg.state == ST_HOLD && !trigActive) |=> !engineStart)
        else $error("holdoff start with inactive trigger");

    c_internal_cycle: cover property (
        r_reg.state == ST_FINISH && !extMode);
    c_external_cycle: cover property (
        r_reg.state == ST_DELAY ##[1:40] r_reg.state == ST_START);
    c_holdoff_wait: cover property (r_reg.state == ST_HOLD);
    c_irq_out: cover property ($fell(intN));
endmodule // adcts_adc_trigger_sequencer
`default_nettype wire

// ---- hdl/adcts_pkg.sv ----
// constants and types for the converter trigger sequencer
package adcts_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] REG_SETUP   = 4'h0;
    localparam logic [3:0] REG_DELAY   = 4'h1;
    localparam logic [3:0] REG_WAIT    = 4'h2;
    localparam logic [3:0] REG_MODE    = 4'h3;
    localparam logic [3:0] REG_READ_HI = 4'h4;
    localparam logic [3:0] REG_READ_LO = 4'h5;
    localparam logic [3:0] REG_MASK    = 4'h6;
    localparam logic [3:0] REG_ACC_HI  = 4'h7;
    localparam logic [3:0] REG_ACC_LO  = 4'h8;
    // setup register fields
    localparam int SET_EN_BIT  = 0;
    localparam int SET_REF_BIT = 1;
    localparam int SET_CH_LSB  = 2;
    localparam int SET_CNT_LSB = 5;
    // delay register fields
    localparam int DLY_EDGE_BIT = 4;
    localparam int DLY_EXT_BIT  = 5;
    localparam int DLY_HOLD_BIT = 6;
    // readout high register fields
    localparam int RD_STAT_BIT = 7;
    localparam int RD_SEL_LSB  = 5;
    // reset values
    localparam logic [7:0] SETUP_RST  = 8'h00;
    localparam logic [7:0] DELAY_RST  = 8'h00;
    localparam logic [3:0] WAIT_RST   = 4'h0;
    localparam logic [1:0] MODE_RST   = 2'h0;
    localparam logic       MASK_RST   = 1'b1;
    localparam logic       STATUS_RST = 1'b0;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int DELAY_STEP_NS = 50000;
    localparam int WAIT_UNIT_NS  = 20000;
    localparam int DELAY_STEP_CYC = DELAY_STEP_NS / CLK_PERIOD_NS;
    localparam int WAIT_UNIT_CYC  = WAIT_UNIT_NS / CLK_PERIOD_NS;
    localparam int RESULT_W = 10;
    localparam int ACC_W    = 11;
    localparam int SUM_W    = 18;
    localparam int CNT_W    = 20;

    typedef enum logic [1:0] {
        ALU_AVERAGE, ALU_MAXIMUM, ALU_MINIMUM, ALU_NONE
    } adcts_alu_type;

    typedef enum logic [1:0] {
        SEL_AVERAGE, SEL_MINIMUM, SEL_MAXIMUM, SEL_LAST
    } adcts_sel_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ARMED, ST_DELAY, ST_START, ST_CONV, ST_WAIT, ST_HOLD,
        ST_FINISH
    } adcts_state_type;

    // wait time in units of the 20 us step, per wait code
    function automatic logic [10:0] adcts_wait_mult(input logic [3:0] code);
        case (code)
            4'h0:    adcts_wait_mult = 11'h001;
            4'h1:    adcts_wait_mult = 11'h002;
            4'h2:    adcts_wait_mult = 11'h003;
            4'h3:    adcts_wait_mult = 11'h004;
            4'h4:    adcts_wait_mult = 11'h008;
            4'h5:    adcts_wait_mult = 11'h00c;
            4'h6:    adcts_wait_mult = 11'h010;
            4'h7:    adcts_wait_mult = 11'h020;
            4'h8:    adcts_wait_mult = 11'h040;
            4'h9:    adcts_wait_mult = 11'h060;
            4'ha:    adcts_wait_mult = 11'h080;
            4'hb:    adcts_wait_mult = 11'h100;
            4'hc:    adcts_wait_mult = 11'h200;
            4'hd:    adcts_wait_mult = 11'h300;
            default: adcts_wait_mult = 11'h400;
        endcase
    endfunction

    // log2 of the sample count per count code: 1,4,8,...,256
    function automatic logic [3:0] adcts_cnt_shift(input logic [2:0] code);
        adcts_cnt_shift = (code == 3'h0) ? 4'h0 : {1'b0, code} + 4'h1;
    endfunction
endpackage : adcts_pkg

// ---- verification/adcts_engine_model.sv ----
// converter engine model: answers each start with one result, fast or slow
`timescale 1ns/1ns
`default_nettype none
module adcts_engine_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       slow,
    input  wire logic [2:0] channelSel,
    input  wire logic       engineStart,
    output logic            engineDone,
    output logic      [9:0] engineResult
);
    int         convNum;
    int         busyCnt;
    logic [2:0] chHeld;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            convNum      <= 0;
            busyCnt      <= 0;
            chHeld       <= 3'h0;
            engineDone   <= 1'b0;
            engineResult <= 10'h3ff;
        end else begin
            engineDone   <= 1'b0;
            // result lines churn outside the done cycle
            engineResult <= ~engineResult;
            if (engineStart) begin
                busyCnt <= slow ? 9 : 2;
                chHeld  <= channelSel;
            end else if (busyCnt == 1) begin
                busyCnt      <= 0;
                engineDone   <= 1'b1;
                engineResult <= {chHeld, 7'(convNum * 37)};
                convNum      <= convNum + 1;
            end else if (busyCnt > 1) begin
                busyCnt <= busyCnt - 1;
            end
        end
    end
endmodule // adcts_engine_model
`default_nettype wire

// ---- verification/test_adc_trigger_sequencer.sv ----
// testbench for the converter trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module test_adc_trigger_sequencer;
    import adcts_pkg::*;
    logic clk, rstn, regWr, regRd, trigger_pin, slow;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, d, h;
    logic [2:0] channelSel;
    logic refRegEnable, engineStart, engineDone, intN;
    logic [9:0] engineResult, r;
    logic [9:0] ex [4];
    int fails, samples_checked, starts, n0, c, s, m, i, cyc, lastDone, minGap;

    adcts_adc_trigger_sequencer #(
        .DELAY_STEP_CYCLES(4),
        .WAIT_UNIT_CYCLES (3)
    ) u_adcts_adc_trigger_sequencer (
        .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .trigger_pin(trigger_pin), .channelSel(channelSel),
        .refRegEnable(refRegEnable), .engineStart(engineStart),
        .engineDone(engineDone), .engineResult(engineResult), .intN(intN)
    );
    adcts_engine_model u_adcts_engine_model (
        .clk(clk), .rstn(rstn), .slow(slow), .channelSel(channelSel),
        .engineStart(engineStart), .engineDone(engineDone),
        .engineResult(engineResult)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // start count and shortest done-to-start gap
    always @(negedge clk) begin
        cyc++;
        if (engineDone) lastDone = cyc;
        if (engineStart) begin
            starts++;
            if (cyc - lastDone < minGap) minGap = cyc - lastDone;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        regAddr  <= a;
        regWdata <= dat;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] dat);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        dat = regRdata;
        @(posedge clk);
    endtask

    task automatic waitInt();
        for (i = 0; i < 5000 && intN !== 1'b0; i++) @(posedge clk);
        chk(11'(intN), 11'h0);
        rd(REG_READ_HI, d);
        chk(11'(d[7]), 11'h0);
        chk(11'(intN), 11'h1);
    endtask

    task automatic calc(input int ch, input int first, input int cnt);
        int sum, mn, mx, v, k;
        sum = 0;
        mn  = 1023;
        mx  = 0;
        v   = 0;
        for (k = 0; k < cnt; k++) begin
            v = ch * 128 + ((first + k) * 37) % 128;
            sum += v;
            if (v < mn) mn = v;
            if (v > mx) mx = v;
        end
        ex[0] = 10'(sum / cnt);
        ex[1] = 10'(mn);
        ex[2] = 10'(mx);
        ex[3] = 10'(v);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        {regWr, regRd, trigger_pin, slow} = 4'h0;
        regAddr  = 4'h0;
        regWdata = 8'h00;
        rstn     = 1'b0;
        lastDone = -1000;
        minGap   = 1000;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        chk(11'(intN), 11'h1);
        chk(11'(refRegEnable), 11'h1);
        rd(REG_READ_HI, d);
        chk(11'(d), 11'h0);
        wr(4'hc, 8'hff);
        rd(4'hc, d);
        chk(11'(d), 11'h0);
        wr(REG_SETUP, 8'h02);
        chk(11'(refRegEnable), 11'h0);
        wr(REG_SETUP, 8'h00);
        chk(11'(refRegEnable), 11'h1);
        wr(REG_MASK, 8'h00);
        wr(REG_WAIT, 8'h01);
        for (c = 0; c < 8; c++) begin
            slow <= !c[0];
            m = c % 4;
            wr(REG_MODE, 8'(m));
            n0 = starts;
            wr(REG_SETUP, {3'(c), 3'(c), 2'b01});
            rd(REG_READ_HI, d);
            chk(11'(d[7]), 11'h1);
            chk(11'(channelSel), 11'(c));
            if (c == 7) begin
                // selector and enable writes while running
                wr(REG_READ_HI, 8'h20);
                wr(REG_SETUP, {3'(c), 3'(c), 2'b00});
            end
            waitInt();
            if (c == 7) chk(11'(d[6:5]), 11'h3);
            chk(11'(starts - n0), 11'((c == 0) ? 1 : 2 << c));
            calc(c, n0, starts - n0);
            for (s = 0; s < 4; s++) begin
                wr(REG_READ_HI, {1'b0, 2'(s), 5'h00});
                rd(REG_READ_HI, h);
                rd(REG_READ_LO, d);
                chk(11'({h[1:0], d}), 11'(ex[s]));
            end
            rd(REG_ACC_HI, h);
            rd(REG_ACC_LO, d);
            s = (m == 1) ? 2 : (m == 2) ? 1 : m;
            chk({h[2:0], d}, {1'b0, ex[s]});
            wr(REG_SETUP, 8'h00);
        end
        chk(11'(minGap >= 6), 11'h1);
        slow <= 1'b1;
        rd(REG_READ_HI, d);
        chk(11'(d[7]), 11'h0);
        wr(REG_WAIT, 8'h00);
        wr(REG_DELAY, 8'h32);
        n0 = starts;
        wr(REG_SETUP, 8'h01);
        repeat (40) @(posedge clk);
        rd(REG_READ_HI, d);
        chk(11'(d[7]), 11'h1);
        chk(11'(starts - n0), 11'h0);
        trigger_pin <= 1'b1;
        repeat (3) @(posedge clk);
        trigger_pin <= 1'b0;
        repeat (30) @(posedge clk);
        chk(11'(starts - n0), 11'h0);
        trigger_pin <= 1'b1;
        waitInt();
        chk(11'(starts - n0), 11'h1);
        wr(REG_SETUP, 8'h00);
        wr(REG_DELAY, 8'h22);
        n0 = starts;
        wr(REG_SETUP, 8'h01);
        repeat (20) @(posedge clk);
        chk(11'(starts - n0), 11'h0);
        trigger_pin <= 1'b0;
        waitInt();
        chk(11'(starts - n0), 11'h1);
        wr(REG_SETUP, 8'h00);
        wr(REG_DELAY, 8'h70);
        n0 = starts;
        wr(REG_SETUP, 8'h21);
        trigger_pin <= 1'b1;
        repeat (40) @(posedge clk);
        chk(11'(starts - n0), 11'h1);
        for (s = 0; s < 3; s++) begin
            trigger_pin <= 1'b0;
            repeat (3) @(posedge clk);
            trigger_pin <= 1'b1;
            repeat (27) @(posedge clk);
        end
        waitInt();
        chk(11'(starts - n0), 11'h4);
        wr(REG_SETUP, 8'h00);
        wr(REG_DELAY, 8'h30);
        wr(REG_MASK, 8'h01);
        trigger_pin <= 1'b0;
        n0 = starts;
        wr(REG_SETUP, 8'h21);
        trigger_pin <= 1'b1;
        repeat (2) @(posedge clk);
        trigger_pin <= 1'b0;
        d = 8'h80;
        for (i = 0; i < 500 && d[7] !== 1'b0; i++) begin
            chk(11'(intN), 11'h1);
            rd(REG_READ_HI, d);
        end
        chk(11'(d[7]), 11'h0);
        chk(11'(starts - n0), 11'h4);
        end_sim();
    end
endmodule // test_adc_trigger_sequencer
`default_nettype wire
